// ==== src/osc_freq_regs.vh ====
// Register offsets, field positions, reset values and timing counts
`ifndef OSC_FREQ_REGS_VH
`define OSC_FREQ_REGS_VH

// --------------------------------------------------------------
// Register offsets
// --------------------------------------------------------------
`define ADDR_COMMAND_CONTROL      8'h07
`define ADDR_OUTPUT_GATE_CONTROL  8'h11
`define ADDR_HS_DIVIDER_LOW       8'h17
`define ADDR_LS_HS_DIVIDER_PACKED 8'h18
`define ADDR_FEEDBACK_BYTE0       8'h1A
`define ADDR_FEEDBACK_BYTE1       8'h1B
`define ADDR_FEEDBACK_BYTE2       8'h1C
`define ADDR_FEEDBACK_BYTE3       8'h1D
`define ADDR_FEEDBACK_BYTE4       8'h1E
`define ADDR_FEEDBACK_TOP         8'h1F
`define ADDR_CALIBRATION_OVERRIDE 8'h45
`define ADDR_FREQ_OFFSET_BYTE0    8'hE7
`define ADDR_FREQ_OFFSET_BYTE1    8'hE8
`define ADDR_FREQ_OFFSET_BYTE2    8'hE9
`define ADDR_PAGE_SELECT          8'hFF

// --------------------------------------------------------------
// Field positions
// --------------------------------------------------------------
`define BIT_CALIBRATION_START     3
`define BIT_OUTPUT_GATE           0
`define BIT_CALIBRATION_OVERRIDE  7
`define LS_DIV_MSB                6
`define LS_DIV_LSB                4
`define HS_DIV_HIGH_MSB           2
`define HS_DIV_HIGH_LSB           0
`define FB_TOP_MSB                2
`define PAGE_MSB                  1

// --------------------------------------------------------------
// Reset values
// --------------------------------------------------------------
`define RST_COMMAND_CONTROL       8'h00
`define RST_OUTPUT_GATE_CONTROL   8'h01
`define RST_HS_DIVIDER_LOW        8'h54
`define RST_LS_HS_DIVIDER_PACKED  8'h00
`define RST_FEEDBACK_BYTE0        8'h00
`define RST_FEEDBACK_BYTE1        8'h00
`define RST_FEEDBACK_BYTE2        8'h00
`define RST_FEEDBACK_BYTE3        8'h00
`define RST_FEEDBACK_BYTE4        8'h64
`define RST_FEEDBACK_TOP          8'h00
`define RST_CALIBRATION_OVERRIDE  8'h01
`define RST_FREQ_OFFSET           24'h000000
`define RST_PAGE_SELECT           8'h00

// --------------------------------------------------------------
// Timing
// --------------------------------------------------------------
`define CLK_SYS_KHZ               100000
`define CAL_TIME_MS               30
// Thirty milliseconds of the 100 MHz system clock
`define CAL_CYCLES                22'd3000000
`define CAL_COUNT_W               22

`endif

// ==== src/cal_timer.v ====
// Calibration interval timer
`timescale 1ns/100ps
module cal_timer #(
  parameter [21:0] CYCLES = 22'd3000000
) (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        start,
  output reg         busy,
  output reg         done
);

  reg [21:0] remaining;

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      remaining <= 22'h000000;
      busy      <= 1'b0;
      done      <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        // Restart reloads the full interval
        remaining <= CYCLES - 22'd1;
        busy      <= 1'b1;
      end
      else if (busy)
      begin
        if (remaining == 22'h000000)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        else
        begin
          remaining <= remaining - 22'd1;
        end
      end
    end
  end

endmodule

// ==== src/clk_out_gen.v ====
// Divided output clock with a gate that never cuts a pulse
`timescale 1ns/100ps
module clk_out_gen (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire [10:0] half_period,
  input  wire        gate_req,
  output reg         clk_out,
  output reg         gate_on
);

  reg  [10:0] count;
  reg         phase;
  wire [10:0] limit;

  assign limit = (half_period == 11'h000) ? 11'h000 : half_period - 11'd1;

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      count   <= 11'h000;
      phase   <= 1'b0;
      gate_on <= 1'b0;
      clk_out <= 1'b0;
    end
    else
    begin
      if (count >= limit)
      begin
        count <= 11'h000;
        phase <= ~phase;
        // Gate moves only as a new high phase begins
        if (!phase)
        begin
          gate_on <= gate_req;
          clk_out <= gate_req;
        end
        else
        begin
          clk_out <= 1'b0;
        end
      end
      else
      begin
        count <= count + 11'd1;
      end
    end
  end

endmodule

// ==== src/osc_freq_update_and_offset.v ====
// Register file, update sequencing and fine offset of the oscillator
`timescale 1ns/100ps
`include "osc_freq_regs.vh"
module osc_freq_update_and_offset #(
  parameter [21:0] CAL_CYCLES = `CAL_CYCLES
) (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  output reg  [7:0]  reg_rdata,
  output reg         reg_rvalid,
  input  wire        oe_pin,
  output wire        clk_out,
  output wire        out_enabled,
  output wire        cal_busy,
  output wire        cal_done,
  output reg  [10:0] active_hs_div,
  output reg  [2:0]  active_ls_div,
  output reg  [42:0] active_fb_div,
  output reg  [23:0] fine_freq_offset,
  output reg         offset_update
);

  // ------------------------------------------------------------
  // Sequence states
  // ------------------------------------------------------------
  localparam [3:0] ST_RUN     = 4'b0001;
  localparam [3:0] ST_HALTED  = 4'b0010;
  localparam [3:0] ST_CAL     = 4'b0100;
  localparam [3:0] ST_SETTLED = 4'b1000;

  reg  [3:0]  state;
  reg  [3:0]  next_state;

  localparam [7:0] RST_PACKED = `RST_LS_HS_DIVIDER_PACKED;
  localparam [7:0] RST_FB_TOP = `RST_FEEDBACK_TOP;
  localparam [7:0] RST_PAGE   = `RST_PAGE_SELECT;

  // ------------------------------------------------------------
  // Shadow registers
  // ------------------------------------------------------------
  reg  [1:0]  page;
  reg         calibration_override_bit;
  reg         output_gate_bit;
  reg  [7:0]  hs_divider_low;
  reg  [2:0]  low_speed_out_divider;
  reg  [2:0]  hs_divider_high;
  reg  [7:0]  fb_byte0;
  reg  [7:0]  fb_byte1;
  reg  [7:0]  fb_byte2;
  reg  [7:0]  fb_byte3;
  reg  [7:0]  fb_byte4;
  reg  [2:0]  fb_top;
  reg  [7:0]  offset_byte0;
  reg  [7:0]  offset_byte1;
  reg  [7:0]  offset_byte2;

  // ------------------------------------------------------------
  // Pin synchroniser
  // ------------------------------------------------------------
  reg         oe_meta;
  reg         oe_s2;
  reg         oe_s3;
  reg         oe_level;

  wire        page_zero;
  wire        wr_hit;
  wire        cal_start;
  wire        cal_load_now;
  wire        gate_req;
  wire [10:0] half_period;

  assign page_zero = (page == 2'b00);
  assign wr_hit    = reg_write & (page_zero |
                     (reg_addr == `ADDR_PAGE_SELECT));

  // Start request with override cleared runs a calibration
  assign cal_start = wr_hit & (reg_addr == `ADDR_COMMAND_CONTROL) &
                     reg_wdata[`BIT_CALIBRATION_START] &
                     ~calibration_override_bit;

  // With override set, dividers load at once and no wait follows
  assign cal_load_now = wr_hit & (reg_addr == `ADDR_COMMAND_CONTROL) &
                        reg_wdata[`BIT_CALIBRATION_START] &
                        calibration_override_bit;

  // Output held off while calibrating, else gate bit and pin
  assign gate_req = output_gate_bit & oe_level &
                    (state != ST_CAL);

  assign half_period = active_hs_div;

  // ------------------------------------------------------------
  // Pin synchroniser
  // ------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      oe_meta  <= 1'b0;
      oe_s2    <= 1'b0;
      oe_s3    <= 1'b0;
      oe_level <= 1'b0;
    end
    else
    begin
      oe_meta <= oe_pin;
      oe_s2   <= oe_meta;
      oe_s3   <= oe_s2;
      if (oe_s2 == oe_s3)
      begin
        oe_level <= oe_s3;
      end
    end
  end

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      page                     <= RST_PAGE[1:0];
      calibration_override_bit <= 1'b0;
      output_gate_bit          <= 1'b1;
      hs_divider_low           <= `RST_HS_DIVIDER_LOW;
      low_speed_out_divider    <= 3'b000;
      hs_divider_high          <= 3'b000;
      fb_byte0                 <= `RST_FEEDBACK_BYTE0;
      fb_byte1                 <= `RST_FEEDBACK_BYTE1;
      fb_byte2                 <= `RST_FEEDBACK_BYTE2;
      fb_byte3                 <= `RST_FEEDBACK_BYTE3;
      fb_byte4                 <= `RST_FEEDBACK_BYTE4;
      fb_top                   <= 3'b000;
      offset_byte0             <= 8'h00;
      offset_byte1             <= 8'h00;
      offset_byte2             <= 8'h00;
    end
    else if (wr_hit)
    begin
      case (reg_addr)
        `ADDR_PAGE_SELECT:
          page <= reg_wdata[`PAGE_MSB:0];
        `ADDR_CALIBRATION_OVERRIDE:
          calibration_override_bit <=
            reg_wdata[`BIT_CALIBRATION_OVERRIDE];
        `ADDR_OUTPUT_GATE_CONTROL:
          output_gate_bit <= reg_wdata[`BIT_OUTPUT_GATE];
        `ADDR_HS_DIVIDER_LOW:
          hs_divider_low <= reg_wdata;
        `ADDR_LS_HS_DIVIDER_PACKED:
        begin
          low_speed_out_divider <=
            reg_wdata[`LS_DIV_MSB:`LS_DIV_LSB];
          hs_divider_high <=
            reg_wdata[`HS_DIV_HIGH_MSB:`HS_DIV_HIGH_LSB];
        end
        `ADDR_FEEDBACK_BYTE0:
          fb_byte0 <= reg_wdata;
        `ADDR_FEEDBACK_BYTE1:
          fb_byte1 <= reg_wdata;
        `ADDR_FEEDBACK_BYTE2:
          fb_byte2 <= reg_wdata;
        `ADDR_FEEDBACK_BYTE3:
          fb_byte3 <= reg_wdata;
        `ADDR_FEEDBACK_BYTE4:
          fb_byte4 <= reg_wdata;
        `ADDR_FEEDBACK_TOP:
          fb_top <= reg_wdata[`FB_TOP_MSB:0];
        `ADDR_FREQ_OFFSET_BYTE0:
          offset_byte0 <= reg_wdata;
        `ADDR_FREQ_OFFSET_BYTE1:
          offset_byte1 <= reg_wdata;
        `ADDR_FREQ_OFFSET_BYTE2:
          offset_byte2 <= reg_wdata;
        default:
          page <= page;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Active divider configuration
  // ------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      active_hs_div <= {RST_PACKED[2:0],
                        `RST_HS_DIVIDER_LOW};
      active_ls_div <= RST_PACKED[6:4];
      active_fb_div <= {RST_FB_TOP[2:0], `RST_FEEDBACK_BYTE4,
                        `RST_FEEDBACK_BYTE3, `RST_FEEDBACK_BYTE2,
                        `RST_FEEDBACK_BYTE1, `RST_FEEDBACK_BYTE0};
    end
    else if (cal_start | cal_load_now)
    begin
      // Shadow bytes take hold only here
      active_hs_div <= {hs_divider_high, hs_divider_low};
      active_ls_div <= low_speed_out_divider;
      active_fb_div <= {fb_top, fb_byte4, fb_byte3, fb_byte2,
                        fb_byte1, fb_byte0};
    end
  end

  // ------------------------------------------------------------
  // Fine offset
  // ------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      fine_freq_offset <= `RST_FREQ_OFFSET;
      offset_update    <= 1'b0;
    end
    else
    begin
      offset_update <= 1'b0;
      // Top byte commits all 24 bits in one edge
      if (wr_hit && (reg_addr == `ADDR_FREQ_OFFSET_BYTE2))
      begin
        fine_freq_offset <= {reg_wdata, offset_byte1,
                             offset_byte0};
        offset_update    <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Update sequence tracking
  // ------------------------------------------------------------
  always @*
  begin
    next_state = state;
    case (state)
      ST_RUN:
        if (cal_start)
          next_state = ST_CAL;
        else if (!output_gate_bit)
          next_state = ST_HALTED;
      ST_HALTED:
        if (cal_start)
          next_state = ST_CAL;
        else if (output_gate_bit)
          next_state = ST_RUN;
      ST_CAL:
        if (cal_done)
          next_state = ST_SETTLED;
      ST_SETTLED:
        if (cal_start)
          next_state = ST_CAL;
        else if (output_gate_bit)
          next_state = ST_RUN;
      default:
        next_state = ST_RUN;
    endcase
  end

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      state <= ST_RUN;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ------------------------------------------------------------
  // Register reads
  // ------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_read;
      if (reg_read)
      begin
        if (!page_zero && (reg_addr != `ADDR_PAGE_SELECT))
        begin
          reg_rdata <= 8'h00;
        end
        else
        begin
          case (reg_addr)
            `ADDR_PAGE_SELECT:
              reg_rdata <= {6'b000000, page};
            `ADDR_COMMAND_CONTROL:
              // Start bit reads back as busy, clears itself
              reg_rdata <= {4'h0, cal_busy, 3'b000};
            `ADDR_OUTPUT_GATE_CONTROL:
              reg_rdata <= {7'h00, output_gate_bit};
            `ADDR_HS_DIVIDER_LOW:
              reg_rdata <= hs_divider_low;
            `ADDR_LS_HS_DIVIDER_PACKED:
              reg_rdata <= {1'b0, low_speed_out_divider, 1'b0,
                            hs_divider_high};
            `ADDR_FEEDBACK_BYTE0:
              reg_rdata <= fb_byte0;
            `ADDR_FEEDBACK_BYTE1:
              reg_rdata <= fb_byte1;
            `ADDR_FEEDBACK_BYTE2:
              reg_rdata <= fb_byte2;
            `ADDR_FEEDBACK_BYTE3:
              reg_rdata <= fb_byte3;
            `ADDR_FEEDBACK_BYTE4:
              reg_rdata <= fb_byte4;
            `ADDR_FEEDBACK_TOP:
              reg_rdata <= {5'b00000, fb_top};
            `ADDR_CALIBRATION_OVERRIDE:
              reg_rdata <= {calibration_override_bit, 7'b0000001};
            `ADDR_FREQ_OFFSET_BYTE0:
              reg_rdata <= offset_byte0;
            `ADDR_FREQ_OFFSET_BYTE1:
              reg_rdata <= offset_byte1;
            `ADDR_FREQ_OFFSET_BYTE2:
              reg_rdata <= offset_byte2;
            default:
              reg_rdata <= 8'h00;
          endcase
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Calibration timer and output clock
  // ------------------------------------------------------------
  cal_timer #(
    .CYCLES (CAL_CYCLES)
  ) u_cal_timer (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (cal_start),
    .busy    (cal_busy),
    .done    (cal_done)
  );

  clk_out_gen u_clk_out_gen (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .half_period (half_period),
    .gate_req    (gate_req),
    .clk_out     (clk_out),
    .gate_on     (out_enabled)
  );

endmodule

// ==== tb/osc_host_model.sv ====
// Host model that programs the oscillator registers
`timescale 1ns/100ps
module osc_host_model #(
  parameter integer CAL_WAIT = 24
) (
  input  wire       clk_sys,
  output reg  [7:0] reg_addr,
  output reg  [7:0] reg_wdata,
  output reg        reg_write,
  output reg        reg_read,
  input  wire [7:0] reg_rdata,
  input  wire       reg_rvalid
);
  localparam integer MAX_STEP = 8161512;
  integer    i;
  reg [47:0] fbx;
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end
  // --------
  // Bus cycles
  // --------
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(negedge clk_sys);
      reg_addr = a;
      reg_wdata = v;
      reg_write = 1'b1;
      @(negedge clk_sys);
      reg_write = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~v;
    end
  endtask
  task rd(input [7:0] a, output [7:0] v, output ok);
    begin
      @(negedge clk_sys);
      reg_addr = a;
      reg_read = 1'b1;
      @(negedge clk_sys);
      reg_read = 1'b0;
      reg_addr = ~a;
      ok = reg_rvalid;
      v = reg_rdata;
    end
  endtask
  task freq_update(input [10:0] hs, input [2:0] ls, input [42:0] fb);
    begin
      fbx = {5'h00, fb};
      wr(8'hFF, 8'h00);
      wr(8'h45, 8'h00);
      wr(8'h11, 8'h00);
      wr(8'h17, hs[7:0]);
      wr(8'h18, {1'b0, ls, 1'b0, hs[10:8]});
      for (i = 0; i < 6; i = i + 1)
        wr(8'h1A + i[7:0], fbx[8*i +: 8]);
      wr(8'h07, 8'h08);
      repeat (CAL_WAIT) @(negedge clk_sys);
      wr(8'h11, 8'h01);
    end
  endtask
  task set_offset(input integer m, output ok);
    begin
      ok = (m <= MAX_STEP) && (m >= -MAX_STEP);
      if (ok)
      begin
        wr(8'hE7, m[7:0]);
        wr(8'hE8, m[15:8]);
        wr(8'hE9, m[23:16]);
      end
    end
  endtask
endmodule

// ==== tb/osc_freq_update_and_offset_chk.sv ====
// Concurrent checks on the oscillator control block
`timescale 1ns/100ps
module osc_freq_update_and_offset_chk #(
  parameter [21:0] CAL_CYCLES = 22'd3000000
) (
  input wire        clk_sys,
  input wire        rst,
  input wire [7:0]  reg_addr,
  input wire [7:0]  reg_wdata,
  input wire        reg_write,
  input wire        clk_out,
  input wire        out_enabled,
  input wire        cal_busy,
  input wire        cal_done,
  input wire [10:0] active_hs_div,
  input wire [2:0]  active_ls_div,
  input wire [42:0] active_fb_div,
  input wire [23:0] fine_freq_offset,
  input wire        offset_update
);
  reg [1:0]  pg;
  reg        ovr;
  reg [15:0] lo;
  reg [21:0] cnt;
  wire p0 = reg_write && (pg == 2'b00);
  wire wr_top = p0 && (reg_addr == 8'hE9);
  wire wr_go = p0 && (reg_addr == 8'h07) && reg_wdata[3];
  // --------
  // Shadow of host writes
  // --------
  always @(posedge clk_sys)
  begin
    if (rst)
      pg <= 2'b00;
    else if (reg_write && reg_addr == 8'hFF)
      pg <= reg_wdata[1:0];
    if (rst)
      ovr <= 1'b0;
    else if (p0 && reg_addr == 8'h45)
      ovr <= reg_wdata[7];
    if (rst)
      lo <= 16'h0000;
    else if (p0 && reg_addr == 8'hE7)
      lo[7:0] <= reg_wdata;
    else if (p0 && reg_addr == 8'hE8)
      lo[15:8] <= reg_wdata;
    if (rst || wr_go)
      cnt <= 22'h000000;
    else if (cal_busy)
      cnt <= cnt + 22'h000001;
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  a_offset_commit: assert property (wr_top |=> offset_update)
    else $error("offset not committed");
  a_offset_value: assert property (wr_top |=>
    fine_freq_offset == {$past(reg_wdata), lo})
    else $error("offset value wrong");
  a_offset_hold: assert property (!wr_top |=>
    $stable(fine_freq_offset) && !offset_update)
    else $error("offset changed without top byte");
  a_cal_start: assert property (wr_go && !ovr |=> cal_busy)
    else $error("calibration did not start");
  a_div_hold: assert property (!wr_go |=>
    $stable({active_hs_div, active_ls_div, active_fb_div}))
    else $error("active dividers changed");
  a_cal_length: assert property (cal_done |->
    cnt == CAL_CYCLES && !cal_busy)
    else $error("calibration length wrong");
  a_gate_clean: assert property ($fell(out_enabled) |->
    !clk_out && !$past(clk_out))
    else $error("gate closed mid pulse");
  a_pulse_gated: assert property (clk_out |-> out_enabled)
    else $error("pulse while gated");
  a_gate_off: assert property (p0 && reg_addr == 8'h11 &&
    !reg_wdata[0] |-> ##[1:600] !out_enabled)
    else $error("gate did not close");
endmodule

bind osc_freq_update_and_offset osc_freq_update_and_offset_chk #(
  .CAL_CYCLES(CAL_CYCLES)
) u_chk (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .clk_out(clk_out),
  .out_enabled(out_enabled), .cal_busy(cal_busy), .cal_done(cal_done),
  .active_hs_div(active_hs_div), .active_ls_div(active_ls_div),
  .active_fb_div(active_fb_div), .fine_freq_offset(fine_freq_offset),
  .offset_update(offset_update)
);

// ==== tb/osc_freq_update_and_offset_tb.sv ====
// Self-checking bench for the oscillator control block
`timescale 1ns/100ps
module osc_freq_update_and_offset_tb;
  reg         clk_sys;
  reg         rst;
  reg         oe_pin;
  wire [7:0]  reg_addr;
  wire [7:0]  reg_wdata;
  wire        reg_write;
  wire        reg_read;
  wire [7:0]  reg_rdata;
  wire        reg_rvalid;
  wire        clk_out;
  wire        out_enabled;
  wire        cal_busy;
  wire        cal_done;
  wire [10:0] active_hs_div;
  wire [2:0]  active_ls_div;
  wire [42:0] active_fb_div;
  wire [23:0] fine_freq_offset;
  wire        offset_update;
  integer     n_mismatch;
  integer     total_checks;
  integer     seed;
  integer     k;
  integer     m;
  integer     w;
  reg [7:0]   d;
  reg         ok;
  reg [10:0]  hs;
  reg [63:0]  fb;
  reg [23:0]  prev;
  osc_freq_update_and_offset #(.CAL_CYCLES(22'd20)) dut (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .oe_pin(oe_pin),
    .clk_out(clk_out), .out_enabled(out_enabled), .cal_busy(cal_busy),
    .cal_done(cal_done), .active_hs_div(active_hs_div),
    .active_ls_div(active_ls_div), .active_fb_div(active_fb_div),
    .fine_freq_offset(fine_freq_offset), .offset_update(offset_update)
  );
  osc_host_model #(.CAL_WAIT(24)) h (
    .clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid)
  );
  always #5 clk_sys = ~clk_sys;
  // --------
  // Expectations and checks
  // --------
  function [7:0] exp_rst(input [7:0] a);
    case (a)
      8'h11, 8'h45: exp_rst = 8'h01;
      8'h17: exp_rst = 8'h54;
      8'h1E: exp_rst = 8'h64;
      default: exp_rst = 8'h00;
    endcase
  endfunction
  function [7:0] exp_rb(input [7:0] a, input [7:0] v);
    case (a)
      8'h18: exp_rb = v & 8'h77;
      8'h19: exp_rb = 8'h00;
      8'h1F: exp_rb = v & 8'h07;
      default: exp_rb = v;
    endcase
  endfunction
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [63:0] got, input [63:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wait_en(input v);
    begin
      w = 0;
      while (out_enabled !== v && w < 600)
      begin
        @(negedge clk_sys);
        w = w + 1;
      end
      chk(out_enabled, v);
      if (out_enabled !== v)
        wrap_up;
    end
  endtask
  // --------
  // Main sequence
  // --------
  initial
  begin
    clk_sys = 1'b0;
    rst = 1'b1;
    oe_pin = 1'b1;
    n_mismatch = 0;
    total_checks = 0;
    seed = 81404;
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    for (k = 0; k < 256; k = k + 1)
    begin
      h.rd(k[7:0], d, ok);
      chk({ok, d}, {1'b1, exp_rst(k[7:0])});
    end
    chk({active_hs_div, active_fb_div}, {11'h054, 43'h06400000000});
    $display("test reset values done");
    for (k = 8'h17; k <= 8'h1F; k = k + 1)
    begin
      m = $random(seed);
      h.wr(k[7:0], m[7:0]);
      h.rd(k[7:0], d, ok);
      chk(d, exp_rb(k[7:0], m[7:0]));
    end
    chk(active_hs_div, 11'h054);
    $display("test shadow writes done");
    h.freq_update(11'h046, 3'h0, 43'h047E756E62A);
    chk({active_ls_div, active_hs_div, active_fb_div},
        {3'h0, 11'h046, 43'h047E756E62A});
    h.rd(8'h07, d, ok);
    chk(d, 8'h00);
    wait_en(1'b1);
    for (k = 0; k < 2; k = k + 1)
    begin
      m = {$random(seed)} % 29;
      hs = 11'd5 + m[10:0];
      fb = {$random(seed), $random(seed)};
      m = $random(seed);
      h.freq_update(hs, m[2:0], fb[42:0]);
      chk({active_ls_div, active_hs_div, active_fb_div},
          {m[2:0], hs, fb[42:0]});
      wait_en(1'b1);
    end
    h.wr(8'h45, 8'hFF);
    h.rd(8'h45, d, ok);
    chk(d, 8'h81);
    h.wr(8'h07, 8'h08);
    chk(cal_busy, 1'b0);
    h.wr(8'h45, 8'h00);
    $display("test frequency update done");
    oe_pin = 1'b0;
    wait_en(1'b0);
    oe_pin = 1'b1;
    wait_en(1'b1);
    h.wr(8'h11, 8'h00);
    wait_en(1'b0);
    h.wr(8'h11, 8'h01);
    wait_en(1'b1);
    $display("test output gate done");
    prev = fine_freq_offset;
    h.wr(8'hE7, 8'h5A);
    h.wr(8'hE8, 8'hA5);
    chk(fine_freq_offset, prev);
    h.wr(8'hE9, 8'h80);
    chk(fine_freq_offset, 24'h80A55A);
    for (k = 0; k < 12; k = k + 1)
    begin
      case (k)
        0: m = 8161512;
        1: m = -8161512;
        2: m = 8161513;
        3: m = -8161513;
        4: m = 0;
        default: m = $random(seed) % 8161513;
      endcase
      prev = fine_freq_offset;
      h.set_offset(m, ok);
      chk(ok, k != 2 && k != 3);
      chk(fine_freq_offset, ok ? m[23:0] : prev);
    end
    $display("test fine offset done");
    wrap_up;
  end
endmodule
